/* File: dv/psc_key_model.sv */
// Partner model: the front-panel switch and the controller's sleep line.
// Assumes bench commands change just after a rising clock edge.
`timescale 1ns/1ns

module psc_key_model (
	input  wire logic press_cmd,      // Key held down, or slider in on position
	input  wire logic sleep_cmd,      // Controller wants the sleep line high
	output logic      power_key_n,    // Pin, pulled up to system_rail when open
	output logic      sleep_request   // Controller push-pull output
);
	// ==========================================================
	// Switch contact
	// ==========================================================
	// Open contact leaves the pull-up, so the idle level is high
	assign power_key_n = ~press_cmd;

	// ==========================================================
	// Controller sleep line
	// ==========================================================
	// Raised after power-up, dropped once its own off timing has run out
	assign sleep_request = sleep_cmd;
endmodule

/* File: dv/psc_top_tb.sv */
// Self-checking bench for the power switch control block.
// Assumes a short debounce parameter; switch and controller come from the model.
`timescale 1ns/1ns

module psc_top_tb;
	import psc_pkg::*;

	// ==========================================================
	// Signals
	// ==========================================================
	localparam int unsigned DEB = 8;   // Short debounce keeps the run brief
	logic clock           = 1'b0;
	logic rst             = 1'b1;
	logic key_type_select = 1'b1;      // Start in push-button mode
	logic press_cmd       = 1'b0;
	logic sleep_cmd       = 1'b0;
	logic power_key_n;
	logic sleep_request;
	logic boost_enable;
	logic regulator_enable;
	logic system_on;
	logic powerup_busy;
	logic supervisor_active;
	logic charger_active;
	int   mismatches = 0;
	int   checks     = 0;
	int   t_on;                        // Press-to-answer time, power on
	int   t_off;                       // Press-to-answer time, power off

	always #4 clock = ~clock;

	psc_key_model i_model (
		.press_cmd     (press_cmd),
		.sleep_cmd     (sleep_cmd),
		.power_key_n   (power_key_n),
		.sleep_request (sleep_request)
	);

	psc_top #(.DEB_CYCLES(DEB)) i_dut (
		.clock             (clock),
		.rst               (rst),
		.key_type_select   (key_type_select),
		.power_key_n       (power_key_n),
		.sleep_request     (sleep_request),
		.boost_enable      (boost_enable),
		.regulator_enable  (regulator_enable),
		.system_on         (system_on),
		.powerup_busy      (powerup_busy),
		.supervisor_active (supervisor_active),
		.charger_active    (charger_active)
	);

	// ==========================================================
	// Shared tasks
	// ==========================================================
	// Wait edges, then let that edge's updates settle
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic chk(input string name, input logic exp, input logic seen);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %b seen %b", name, exp, seen);
		end
	endtask

	// Press key, count edges until the regulator enable flips (bounded)
	task automatic press(output int n);
		logic start;
		start = regulator_enable;
		@(posedge clock);
		press_cmd <= 1'b1;
		n = 0;
		cyc(1);
		n = 1;
		while (n < 100 && regulator_enable === start) begin
			cyc(1);
			n++;
		end
	endtask

	// Release key and give the filter time to settle on released
	task automatic release_key();
		@(posedge clock);
		press_cmd <= 1'b0;
		cyc(DEB + 8);
	endtask

	// Bounded wait for normal mode
	task automatic wait_on();
		int k;
		for (k = 0; k < 40 && system_on !== 1'b1; k++) cyc(1);
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	// Press shorter than the debounce time must be ignored
	task automatic t_short();
		@(posedge clock);
		press_cmd <= 1'b1;
		cyc(DEB - 2);
		release_key();
		chk("regulator_enable", 1'b0, regulator_enable);
		chk("boost_enable", 1'b0, boost_enable);
		chk("system_on", 1'b0, system_on);
		chk("supervisor_active", 1'b1, supervisor_active);
		chk("charger_active", 1'b1, charger_active);
		$display("test short press done");
	endtask

	// Full press powers up; release must not toggle back
	task automatic t_push_on();
		press(t_on);
		chk("on time in range", 1'b1, t_on > DEB && t_on <= DEB + 6);
		chk("powerup_busy", 1'b1, powerup_busy);
		chk("boost_enable in powerup", 1'b0, boost_enable);
		wait_on();
		chk("system_on", 1'b1, system_on);
		chk("boost_enable", 1'b1, boost_enable);
		chk("powerup_busy after sequence", 1'b0, powerup_busy);
		release_key();
		chk("system_on after release", 1'b1, system_on);
		$display("test push on done");
	endtask

	// Second press powers down after the same press time
	task automatic t_push_off();
		press(t_off);
		chk("off time equals on time", 1'b1, t_off == t_on);
		chk("regulator_enable", 1'b0, regulator_enable);
		chk("boost_enable", 1'b0, boost_enable);
		release_key();
		chk("system_on", 1'b0, system_on);
		$display("test push off done");
	endtask

	// Slider follows the level with no push-button debounce
	task automatic t_slider();
		int n;
		@(posedge clock);
		key_type_select <= 1'b0;
		cyc(2);
		press(n);
		chk("slider answers before debounce", 1'b1, n < DEB);
		chk("regulator_enable", 1'b1, regulator_enable);
		wait_on();
		chk("system_on", 1'b1, system_on);
		@(posedge clock);
		press_cmd <= 1'b0;
		cyc(6);
		chk("regulator_enable off", 1'b0, regulator_enable);
		chk("system_on off", 1'b0, system_on);
		@(posedge clock);
		key_type_select <= 1'b1;
		cyc(DEB + 8);
		$display("test slider done");
	endtask

	// Controller sleep line forces power down on its falling edge
	task automatic t_sleep();
		int n;
		press(n);
		wait_on();
		release_key();
		@(posedge clock);
		sleep_cmd <= 1'b1;
		cyc(6);
		chk("system_on after sleep high", 1'b1, system_on);
		@(posedge clock);
		sleep_cmd <= 1'b0;
		cyc(6);
		chk("system_on after sleep fall", 1'b0, system_on);
		chk("regulator_enable", 1'b0, regulator_enable);
		$display("test sleep done");
	endtask

	// ==========================================================
	// Verdict and run control
	// ==========================================================
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog: all scenarios need well under a thousand cycles
	initial begin
		#(8 * 5000);
		mismatches++;
		print_verdict();
	end

	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		cyc(2);
		t_short();
		t_push_on();
		t_push_off();
		t_slider();
		t_sleep();
		print_verdict();
	end
endmodule

/* File: hw/psc_key_filter.sv */
// Synchroniser and debounce filter for the power key pin.
// Assumes one clock; key pin idles high and is pulled low when active.
`timescale 1ns/1ns
`include "psc_defs.svh"

module psc_key_filter
	import psc_pkg::*;
#(
	parameter int unsigned DEB_CYCLES = `PSC_DEB_MS * `PSC_CLK_KHZ
) (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic key_raw,    // Power key pin
	output logic      key_sync,   // Synchronised level
	output logic      key_clean   // Debounced level
);

	// ==========================================================
	// State
	// ==========================================================
	// Full-width last count, then cut to the counter on purpose
	localparam int unsigned           DEB_LAST_I = DEB_CYCLES - 1;
	localparam logic [`PSC_DEB_W-1:0] DEB_LAST   = DEB_LAST_I[`PSC_DEB_W-1:0];

	psc_filt_st_t st_ff;   // Registered state
	psc_filt_st_t nxt_st;  // Next state

	// Level must differ from clean value for the whole time before it is taken
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = key_raw;   // R11
		nxt_st.s2 = st_ff.s1;  // R11
		if (st_ff.s2 == st_ff.clean) begin
			// Agreement resets the stable-time count
			nxt_st.cnt = '0;
		end else if (st_ff.cnt == DEB_LAST) begin
			// Same timer for presses and releases
			nxt_st.clean = st_ff.s2;  // R2
			nxt_st.cnt = '0;
		end else begin
			nxt_st.cnt = st_ff.cnt + `PSC_DEB_ONE;
		end
	end

	// Register, released level after reset
	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff.s1 <= `PSC_KEY_IDLE;
			st_ff.s2 <= `PSC_KEY_IDLE;
			st_ff.clean <= `PSC_KEY_IDLE;
			st_ff.cnt <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign key_sync = st_ff.s2;
	assign key_clean = st_ff.clean;

	// ==========================================================
	// Checks
	// ==========================================================
	AST_KEY_SYNC2: assert property (@(posedge clock) disable iff (rst) // R11
		!$past(rst) && !$past(rst, 2) |-> key_sync == $past(key_raw, 2))
		else $error("key sync is not two stages");

	AST_DEB_STABLE: assert property (@(posedge clock) disable iff (rst) // R2
		!$past(rst) && $changed(key_clean) |-> $past(st_ff.cnt) == DEB_LAST)
		else $error("key level taken before debounce time");

endmodule

/* File: hw/psc_top.sv */
// Power on/off control: key filter, power state machine, enables.
// Assumes pins synchronous to one free-running timebase; reset at power-on.
// Notes on behaviour
// R1 - Select pin high push-button, low slider
// R2 - Push-button key debounced 32 ms both ways
// R3 - Press over 32 ms toggles power state
// R4 - Slider grounded starts power-up sequence
// R5 - Slider high off, grounded on
// R6 - Supervisor and charger stay running in sleep
// R7 - Sleep keeps boost and regulator disabled
// R8 - After power-up enter normal mode
// R9 - Sleep line falling after high powers down
// R10 - Controller times custom off, then drops sleep
// R11 - Synchronise key and sleep inputs first
`timescale 1ns/1ns
// Timing counts and pin levels live in the shared header
`include "psc_defs.svh"

module psc_top
	import psc_pkg::*;
#(
	parameter int unsigned DEB_CYCLES = `PSC_DEB_MS * `PSC_CLK_KHZ
) (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic key_type_select,     // High push-button, low slider
	input  wire logic power_key_n,         // Power key pin, low when pressed/on
	input  wire logic sleep_request,       // Controller sleep line
	output logic      boost_enable,        // Boost converter enable
	output logic      regulator_enable,    // Enable of regulator_output
	output logic      system_on,           // Normal operating mode
	output logic      powerup_busy,        // Power-up sequence running
	output logic      supervisor_active,   // Sleep control supervisor alive
	output logic      charger_active       // Charger and power path alive
);

	// ==========================================================
	// Key synchroniser and debounce
	// ==========================================================
	logic key_sync;   // Synchronised key level
	logic key_clean;  // Debounced key level

	psc_key_filter #(
		.DEB_CYCLES (DEB_CYCLES)
	) u_key (
		.clock     (clock),
		.rst       (rst),
		.key_raw   (power_key_n),
		.key_sync  (key_sync),
		.key_clean (key_clean)
	);

	// ==========================================================
	// State
	// ==========================================================
	psc_top_st_t st_ff;   // Registered state
	psc_top_st_t nxt_st;  // Next state

	logic push_mode;   // Push-button selected
	logic press_evt;   // Debounced press edge
	logic slide_on;    // Slider in on position
	logic sleep_fall;  // Sleep line fell after being armed
	logic pu_done;     // Power-up sequence at its end

	// Mode decode is a plain level; strap is read live but meant static
	always_comb begin
		push_mode = (key_type_select == `PSC_SEL_PUSH);  // R1
		press_evt = st_ff.key_d && !key_clean;           // R3
		slide_on = (key_sync != `PSC_KEY_IDLE);          // R5
		sleep_fall = st_ff.armed && st_ff.slp_d && !st_ff.slp_s2;  // R9
		pu_done = (st_ff.pu_cnt == `PSC_PU_LAST);
	end

	// ==========================================================
	// Power state machine
	// ==========================================================
	// Press edge is only seen once the level has held for the debounce time
	always_comb begin
		nxt_st = st_ff;
		// Sleep line synchroniser, first stage feeds only the second
		nxt_st.slp_s1 = sleep_request;  // R11
		nxt_st.slp_s2 = st_ff.slp_s1;   // R11
		nxt_st.slp_d = st_ff.slp_s2;
		nxt_st.key_d = key_clean;
		case (st_ff.state)
			PSC_SLEEP: begin
				nxt_st.pu_cnt = '0;
				nxt_st.armed = 1'b0;
				if (push_mode) begin
					// Debounced press turns the system on
					if (press_evt) begin
						nxt_st.state = PSC_POWERUP;  // R3
					end
				end else if (slide_on) begin
					// Grounded slider starts the sequence
					nxt_st.state = PSC_POWERUP;  // R4
				end
			end
			PSC_POWERUP: begin
				if (push_mode ? press_evt : !slide_on) begin
					// Off request aborts the sequence
					nxt_st.state = PSC_SLEEP;  // R5
				end else if (pu_done) begin
					nxt_st.state = PSC_NORMAL;  // R8
				end else begin
					nxt_st.pu_cnt = st_ff.pu_cnt + `PSC_PU_ONE;
				end
			end
			PSC_NORMAL: begin
				// Controller proves control by raising the line after startup
				if (st_ff.slp_s2) begin
					nxt_st.armed = 1'b1;  // R9
				end
				if (sleep_fall) begin
					// Custom off timing done by the controller
					nxt_st.state = PSC_SLEEP;  // R9
				end else if (push_mode && press_evt) begin
					// Same press time as for power on
					nxt_st.state = PSC_SLEEP;  // R3
				end else if (!push_mode && !slide_on) begin
					// Slider back to rail level turns off
					nxt_st.state = PSC_SLEEP;  // R5
				end
			end
			default: begin
				nxt_st.state = PSC_SLEEP;
			end
		endcase
		// Enables follow the next state so they line up with it
		// Regulator runs first so the controller can boot before the boost
		nxt_st.reg_en = (nxt_st.state != PSC_SLEEP);   // R7
		nxt_st.bst_en = (nxt_st.state == PSC_NORMAL);  // R7
	end

	// Register; sleep with boost and regulator off after reset
	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff.state <= PSC_SLEEP;
			st_ff.pu_cnt <= '0;
			st_ff.slp_s1 <= 1'b0;
			st_ff.slp_s2 <= 1'b0;
			st_ff.slp_d <= 1'b0;
			st_ff.armed <= 1'b0;
			st_ff.key_d <= `PSC_KEY_IDLE;
			st_ff.bst_en <= 1'b0;
			st_ff.reg_en <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Supervisor and charger are never gated by the power state
	assign supervisor_active = 1'b1;  // R6
	assign charger_active = 1'b1;     // R6
	assign boost_enable = st_ff.bst_en;
	assign regulator_enable = st_ff.reg_en;
	assign system_on = (st_ff.state == PSC_NORMAL);
	assign powerup_busy = (st_ff.state == PSC_POWERUP);

	// ==========================================================
	// Checks
	// ==========================================================
	AST_SLEEP_OFF: assert property (@(posedge clock) disable iff (rst) // R7
		st_ff.state == PSC_SLEEP |-> !boost_enable && !regulator_enable)
		else $error("enable high while in sleep");

	AST_ALWAYS_ALIVE: assert property (@(posedge clock) disable iff (rst) // R6
		st_ff.state == PSC_SLEEP |-> supervisor_active && charger_active)
		else $error("supervisor or charger stopped in sleep");

	AST_SLIDE_ON: assert property (@(posedge clock) disable iff (rst) // R4
		st_ff.state == PSC_SLEEP && !push_mode && slide_on
		|=> st_ff.state == PSC_POWERUP && regulator_enable)
		else $error("slider on did not start power-up");

	AST_SLIDE_OFF: assert property (@(posedge clock) disable iff (rst) // R5
		st_ff.state == PSC_NORMAL && !push_mode && !slide_on && !sleep_fall
		|=> st_ff.state == PSC_SLEEP && !regulator_enable)
		else $error("slider off did not power down");

	AST_PUSH_IGNORES_LEVEL: assert property (@(posedge clock) disable iff (rst) // R1
		st_ff.state == PSC_SLEEP && push_mode && !press_evt
		|=> st_ff.state == PSC_SLEEP)
		else $error("push mode left sleep without a press");

	AST_PRESS_ON: assert property (@(posedge clock) disable iff (rst) // R3
		st_ff.state == PSC_SLEEP && push_mode && $fell(key_clean)
		|=> st_ff.state == PSC_POWERUP)
		else $error("press did not power on");

	AST_PRESS_OFF: assert property (@(posedge clock) disable iff (rst) // R3
		st_ff.state == PSC_NORMAL && push_mode && $fell(key_clean)
		|=> st_ff.state == PSC_SLEEP)
		else $error("press did not power off");

	AST_PU_DONE: assert property (@(posedge clock) disable iff (rst) // R8
		st_ff.state == PSC_POWERUP && pu_done
		&& !(push_mode ? press_evt : !slide_on)
		|=> system_on && boost_enable)
		else $error("power-up end did not enter normal");

	AST_SLEEP_LINE: assert property (@(posedge clock) disable iff (rst) // R9
		st_ff.state == PSC_NORMAL && st_ff.armed && $fell(st_ff.slp_s2)
		|=> st_ff.state == PSC_SLEEP)
		else $error("sleep line fall did not power down");

	AST_SLEEP_UNARMED: assert property (@(posedge clock) disable iff (rst) // R9
		st_ff.state == PSC_NORMAL && !st_ff.armed && !press_evt && push_mode
		|=> st_ff.state == PSC_NORMAL)
		else $error("left normal without cause");

	AST_SLP_SYNC2: assert property (@(posedge clock) disable iff (rst) // R11
		!$past(rst) && !$past(rst, 2) |-> st_ff.slp_s2 == $past(sleep_request, 2))
		else $error("sleep line sync is not two stages");

	// Sequence runs its full length unless an off request cuts it
	AST_PU_COUNT: assert property (@(posedge clock) disable iff (rst) // R8
		st_ff.state == PSC_POWERUP && !pu_done && !(push_mode ? press_evt : !slide_on)
		|=> st_ff.state == PSC_POWERUP && !boost_enable)
		else $error("power-up sequence cut short");

	// Boost only ever runs on top of the regulator, in normal mode
	AST_BOOST_NEEDS_REG: assert property (@(posedge clock) disable iff (rst) // R8
		boost_enable |-> regulator_enable && system_on)
		else $error("boost enabled outside normal mode");

endmodule

/* File: include/psc_defs.svh */
// Constants for the power switch control block.
// Assumes inclusion by its bare name from the package and modules.
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

// ==========================================================
// Timebase and debounce
// ==========================================================
`define PSC_CLK_KHZ   125000       // Timebase rate in kHz (8 ns period)
`define PSC_DEB_MS    32           // Debounce time in ms, on and off alike
`define PSC_DEB_W     23           // Debounce counter width
`define PSC_DEB_ONE   23'h00_0001  // Unit step of debounce counter

// ==========================================================
// Power-up sequence
// ==========================================================
`define PSC_PU_W      8            // Power-up counter width
`define PSC_PU_LAST   8'h0F        // Last cycle of power-up sequence
`define PSC_PU_ONE    8'h01        // Unit step of power-up counter

// ==========================================================
// Pin levels
// ==========================================================
`define PSC_KEY_IDLE  1'b1         // Power key released (pulled to rail)
`define PSC_SEL_PUSH  1'b1         // Select level for push-button

`endif

/* File: include/psc_pkg.sv */
// Types shared by the power switch control modules.
// Assumes psc_defs.svh is on the include path.
`include "psc_defs.svh"

package psc_pkg;

	// ==========================================================
	// Power states
	// ==========================================================
	typedef enum logic [1:0] {
		PSC_SLEEP,
		PSC_POWERUP,
		PSC_NORMAL
	} psc_state_t;

	// ==========================================================
	// Key filter state
	// ==========================================================
	typedef struct packed {
		logic                  s1;     // Sync stage one
		logic                  s2;     // Sync stage two
		logic                  clean;  // Debounced level
		logic [`PSC_DEB_W-1:0] cnt;    // Stable-time counter
	} psc_filt_st_t;

	// ==========================================================
	// Top-level state
	// ==========================================================
	typedef struct packed {
		psc_state_t           state;   // Power state
		logic [`PSC_PU_W-1:0] pu_cnt;  // Power-up progress
		logic                 slp_s1;  // Sleep line sync stage one
		logic                 slp_s2;  // Sleep line sync stage two
		logic                 slp_d;   // Sleep line, previous sample
		logic                 armed;   // Sleep line seen high since startup
		logic                 key_d;   // Debounced key, previous sample
		logic                 bst_en;  // Boost enable
		logic                 reg_en;  // Regulator enable
	} psc_top_st_t;

endpackage
